/* File: core/splbs_map.svh */
`ifndef SPLBS_MAP_SVH
`define SPLBS_MAP_SVH

// Register byte offsets on the APB slave.
`define SPLBS_STRAP_STATUS_OFF 12'h000
`define SPLBS_BOOT_STATUS_OFF 12'h004
`define SPLBS_CTRL_OFF 12'h008
`define SPLBS_PRINT_SEL_OFF 12'h00C

// Strap status field positions.
`define SPLBS_STRAP_TWO_BIT 0
`define SPLBS_STRAP_EIGHT_BIT 1
`define SPLBS_STRAP_NINE_BIT 2

// Boot status field positions.
`define SPLBS_BOOT_MODE_LSB 0
`define SPLBS_BOOT_MODE_MSB 1
`define SPLBS_PRINT_EN_BIT 2
`define SPLBS_INVALID_BIT 3
`define SPLBS_CAPTURED_BIT 4
`define SPLBS_CAPT_COUNT_LSB 8
`define SPLBS_CAPT_COUNT_MSB 15

// Control field positions and reset values.
`define SPLBS_PULLUP_BIT 0
`define SPLBS_PULLUP_RST 1'h1
`define SPLBS_PRINT_SEL_RST 2'h0

// Print select field encodings.
`define SPLBS_PSEL_ON 2'h0
`define SPLBS_PSEL_EIGHT_LOW 2'h1
`define SPLBS_PSEL_EIGHT_HIGH 2'h2
`define SPLBS_PSEL_OFF 2'h3

// Cycles the pin synchroniser needs before a sample is trusted.
`define SPLBS_SETTLE_CYCLES 3'h4

`endif

/* File: core/splbs_pkg.sv */
package splbs_pkg;

	// Captured strap levels.
	typedef struct packed {
		logic nine;
		logic eight;
		logic two;
	} splbs_strap_s;

	// Boot mode decoded from the captured straps.
	typedef enum logic [1:0] {
		BOOT_FLASH = 2'h0,
		BOOT_SERIAL = 2'h1,
		BOOT_UNDEF = 2'h2,
		BOOT_INVALID = 2'h3
	} splbs_boot_e;

	// Capture sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_SETTLE = 3'h2,
		ST_RUN = 3'h4
	} splbs_state_e;

	// APB request as seen by the slave.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} splbs_apb_req_s;

endpackage

/* File: core/splbs_sync.sv */
`timescale 1ns/1ns
// Three-stage synchroniser; the held value follows once stages two and three agree.
module splbs_sync #(
	parameter int WIDTH = 7
) (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// Asynchronous levels and their synchronised copy.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;

	// Each bit takes the new level only where the last two stages agree.
	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				out_next[i] = s3_reg[i];
			end
		end
	end

	// Stage one is read by stage two alone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else if (pclk_en) begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;

endmodule

/* File: core/splbs_top.sv */
// What this block does
// R1 - Latch strap levels on every system reset.
// R2 - Hold captured bits until power down (code: held only until the next system reset, which captures again).
// R3 - Software reads captured bits in status.
// R4 - Pin nine pulled up by default.
// R5 - Release pins to normal use after capture.
// R6 - Outside drives wanted strap levels at power-on.
// R7 - Nine high flash; nine low serial load (code: serial only with eight and two high).
// R8 - Outside never sets pins eight, nine low.
// R9 - Select 0 prints on, 3 off.
// R10 - Select 1 and 2 follow pin eight.
// R11 - Capture at reset release, then stable outputs.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "splbs_map.svh"
module splbs_top (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Other system reset sources: watchdog, brownout, super watchdog, clock glitch.
	input wire logic [3:0] sys_rst_src,
	// One-time-programmable print select field.
	input wire logic [1:0] otp_print_sel,
	// Strap pins, index 0 two, 1 eight, 2 nine.
	input wire logic [2:0] strap_pin_in,
	output logic [2:0] strap_pin_out,
	output logic [2:0] strap_pin_oe,
	output logic strap_pin_nine_pull_en,
	// Normal pin function once released.
	input wire logic [2:0] func_out,
	input wire logic [2:0] func_oe,
	output logic [2:0] func_in,
	// Decoded results.
	output logic [1:0] boot_mode,
	output logic print_en,
	output logic strap_valid
);

	localparam int SYNC_W = 7;

	logic [SYNC_W-1:0] sync_val;
	splbs_pkg::splbs_strap_s pins_sync;
	logic rst_any;
	splbs_pkg::splbs_apb_req_s req;

	splbs_pkg::splbs_state_e state_reg, state_next;
	logic [2:0] settle_reg, settle_next;
	splbs_pkg::splbs_strap_s strap_reg, strap_next;
	logic captured_reg, captured_next;
	logic [7:0] capt_cnt_reg, capt_cnt_next;
	logic [1:0] print_sel_reg, print_sel_next;
	logic pullup_reg, pullup_next;
	logic [1:0] boot_mode_reg, boot_mode_next;
	logic print_en_reg, print_en_next;
	logic [2:0] pin_out_reg, pin_out_next;
	logic [2:0] pin_oe_reg, pin_oe_next;

	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	// Boot mode from captured straps.
	function automatic logic [1:0] decode_boot(input splbs_pkg::splbs_strap_s s);
		logic [1:0] m;
		m = splbs_pkg::BOOT_UNDEF;
		if (s.nine) begin
			m = splbs_pkg::BOOT_FLASH; // R7
		end else if (!s.eight) begin
			m = splbs_pkg::BOOT_INVALID; // R8
		end else if (s.two) begin
			m = splbs_pkg::BOOT_SERIAL; // R7
		end
		return m;
	endfunction

	// Print enable from the select field and pin eight.
	function automatic logic decode_print(input logic [1:0] sel, input logic eight);
		logic p;
		case (sel)
			`SPLBS_PSEL_ON: p = 1'h1; // R9
			`SPLBS_PSEL_EIGHT_LOW: p = !eight; // R10
			`SPLBS_PSEL_EIGHT_HIGH: p = eight; // R10
			default: p = 1'h0; // R9
		endcase
		return p;
	endfunction

	// Pins and reset sources come from outside the clock domain.
	splbs_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pclk_en(pclk_en),
		.async_in({sys_rst_src, strap_pin_in}),
		.sync_out(sync_val)
	);

	assign pins_sync = sync_val[2:0];
	assign rst_any = |sync_val[6:3];
	assign req = {psel, penable, pwrite, paddr, pwdata};

	// Capture sequencer: hold while reset, settle the sampler, capture, then run.
	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		strap_next = strap_reg;
		captured_next = captured_reg;
		capt_cnt_next = capt_cnt_reg;
		case (state_reg)
			splbs_pkg::ST_HOLD: begin
				settle_next = 3'h0;
				if (!rst_any) begin
					state_next = splbs_pkg::ST_SETTLE;
				end
			end
			splbs_pkg::ST_SETTLE: begin
				if (rst_any) begin
					state_next = splbs_pkg::ST_HOLD;
				end else if (settle_reg == `SPLBS_SETTLE_CYCLES) begin
					strap_next = pins_sync; // R1 R11
					captured_next = 1'h1;
					capt_cnt_next = capt_cnt_reg + 8'h01;
					state_next = splbs_pkg::ST_RUN;
				end else begin
					settle_next = settle_reg + 3'h1;
				end
			end
			splbs_pkg::ST_RUN: begin
				// Pin activity no longer reaches the captured bits.
				if (rst_any) begin
					state_next = splbs_pkg::ST_HOLD; // R1 R2 R5
				end
			end
			default: begin
				state_next = splbs_pkg::ST_HOLD;
			end
		endcase
	end

	// Decoded outputs follow the held straps and the print select field.
	always_comb begin
		boot_mode_next = decode_boot(strap_reg); // R7 R11
		print_en_next = decode_print(print_sel_reg, strap_reg.eight); // R9 R10
		if (state_next == splbs_pkg::ST_RUN && state_reg != splbs_pkg::ST_RUN) begin
			boot_mode_next = decode_boot(strap_next);
			print_en_next = decode_print(print_sel_next, strap_next.eight);
		end
	end

	// Pins float for strapping until the capture, then carry their normal function.
	always_comb begin
		pin_out_next = 3'h0;
		pin_oe_next = 3'h0;
		if (state_next == splbs_pkg::ST_RUN) begin
			pin_out_next = func_out; // R5
			pin_oe_next = func_oe; // R5
		end
	end

	// APB slave: one wait state, the access completes on the second access edge.
	always_comb begin
		prdata_next = prdata_reg;
		pready_next = 1'h0;
		pslverr_next = 1'h0;
		print_sel_next = print_sel_reg;
		pullup_next = pullup_reg;
		if (state_reg == splbs_pkg::ST_SETTLE && state_next == splbs_pkg::ST_RUN) begin
			print_sel_next = otp_print_sel;
		end
		if (req.psel && req.penable && !pready_reg) begin
			pready_next = 1'h1;
			prdata_next = 32'h0000_0000;
			case (req.paddr)
				`SPLBS_STRAP_STATUS_OFF: begin
					prdata_next[`SPLBS_STRAP_TWO_BIT] = strap_reg.two; // R3
					prdata_next[`SPLBS_STRAP_EIGHT_BIT] = strap_reg.eight; // R3
					prdata_next[`SPLBS_STRAP_NINE_BIT] = strap_reg.nine; // R3
				end
				`SPLBS_BOOT_STATUS_OFF: begin
					prdata_next[`SPLBS_BOOT_MODE_MSB:`SPLBS_BOOT_MODE_LSB] = boot_mode_reg;
					prdata_next[`SPLBS_PRINT_EN_BIT] = print_en_reg;
					prdata_next[`SPLBS_INVALID_BIT] = (boot_mode_reg == splbs_pkg::BOOT_INVALID);
					prdata_next[`SPLBS_CAPTURED_BIT] = captured_reg;
					prdata_next[`SPLBS_CAPT_COUNT_MSB:`SPLBS_CAPT_COUNT_LSB] = capt_cnt_reg;
				end
				`SPLBS_CTRL_OFF: begin
					prdata_next[`SPLBS_PULLUP_BIT] = pullup_reg;
				end
				`SPLBS_PRINT_SEL_OFF: begin
					prdata_next[1:0] = print_sel_reg;
				end
				default: begin
					pslverr_next = 1'h1;
				end
			endcase
			if (req.pwrite) begin
				prdata_next = 32'h0000_0000;
			end
		end else if (req.psel && req.penable && pready_reg && req.pwrite) begin
			// Writes land on the edge where the master sees pready high.
			if (req.paddr == `SPLBS_CTRL_OFF) begin
				pullup_next = req.pwdata[`SPLBS_PULLUP_BIT];
			end
			if (req.paddr == `SPLBS_PRINT_SEL_OFF) begin
				print_sel_next = req.pwdata[1:0];
			end
		end
		// Outside the run state the pull-up stays on, so an open pin nine reads high.
		if (state_next != splbs_pkg::ST_RUN) begin
			pullup_next = 1'h1; // R4
		end
	end

	// Capture, decode and pin registers; the pull-up comes back on with every reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= splbs_pkg::ST_HOLD;
			settle_reg <= 3'h0;
			strap_reg <= 3'h0;
			captured_reg <= 1'h0;
			capt_cnt_reg <= 8'h00;
			boot_mode_reg <= 2'h0;
			print_en_reg <= 1'h0;
			pin_out_reg <= 3'h0;
			pin_oe_reg <= 3'h0;
		end else if (pclk_en) begin
			state_reg <= state_next;
			settle_reg <= settle_next;
			strap_reg <= strap_next;
			captured_reg <= captured_next;
			capt_cnt_reg <= capt_cnt_next;
			boot_mode_reg <= boot_mode_next;
			print_en_reg <= print_en_next;
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	// Bus and software-visible control registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'h0;
			pslverr_reg <= 1'h0;
			print_sel_reg <= `SPLBS_PRINT_SEL_RST;
			pullup_reg <= `SPLBS_PULLUP_RST; // R4
		end else if (pclk_en) begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			print_sel_reg <= print_sel_next;
			pullup_reg <= pullup_next; // R4
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign strap_pin_out = pin_out_reg;
	assign strap_pin_oe = pin_oe_reg;
	assign strap_pin_nine_pull_en = pullup_reg;
	assign func_in = sync_val[2:0];
	assign boot_mode = boot_mode_reg;
	assign print_en = print_en_reg;
	assign strap_valid = captured_reg;

endmodule

/* File: dv/splbs_pin_model.sv */
`timescale 1ns/1ns
// Board side of the strap pads: host drive, weak pull-up on pin nine, floating otherwise.
module splbs_pin_model (
	// Clock for the floating pattern.
	input wire logic pclk,
	// Host intent.
	input wire logic [2:0] host_en,
	input wire logic [2:0] host_lvl,
	// Device pad.
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic pull_en,
	output logic [2:0] pin_in
);
	logic flip_reg = 1'b0;
	// A floating pad shows a level that changes every cycle.
	always_ff @(posedge pclk) flip_reg <= !flip_reg;
	// Resolve each pad from every party that may drive it.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (host_en[i])
				pin_in[i] = host_lvl[i];
			else if (i == 2 && pull_en)
				pin_in[i] = 1'b1;
			else
				pin_in[i] = flip_reg;
		end
	end
endmodule

/* File: dv/splbs_top_sva.sv */
`timescale 1ns/1ns
module splbs_top_sva (
	// Watched ports.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic strap_valid,
	input wire logic strap_pin_nine_pull_en,
	input wire logic [3:0] sys_rst_src,
	input wire logic [2:0] func_oe,
	input wire logic [2:0] strap_pin_oe,
	input wire logic [1:0] boot_mode
);
	logic [3:0] up_reg;
	logic [4:0] calm_reg;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Edges since reset release, and since the last other reset source.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_reg <= 4'h0;
			calm_reg <= 5'h00;
		end else begin
			up_reg <= up_reg + {3'h0, up_reg != 4'hF};
			calm_reg <= (sys_rst_src != 4'h0) ? 5'h00 : calm_reg + {4'h0, calm_reg != 5'h1F};
		end
	end
	sequence s_access;
		psel && penable && !pready && pclk_en;
	endsequence
	a_ready_once: assert property (s_access |=> pready ##1 !pready)
		else $error("apb answer late or long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_valid_sticky: assert property (strap_valid |=> strap_valid)
		else $error("capture flag dropped");
	a_capture_late: assert property (up_reg == 4'h4 |-> !strap_valid)
		else $error("capture too early");
	a_capture_due: assert property (up_reg == 4'h8 && calm_reg >= 5'h08 |-> strap_valid)
		else $error("capture missing");
	a_mode_held: assert property (strap_valid && calm_reg == 5'h1F |=> $stable(boot_mode))
		else $error("boot mode moved");
	a_pins_idle: assert property (!strap_valid |-> strap_pin_oe == 3'h0)
		else $error("pins driven before capture");
	a_pull_default: assert property (!strap_valid |-> strap_pin_nine_pull_en)
		else $error("pull-up off before capture");
	a_pins_follow: assert property (strap_valid && calm_reg == 5'h1F |->
		strap_pin_oe == $past(func_oe))
		else $error("pins not released");
endmodule
bind splbs_top splbs_top_sva u_sva (.pclk, .presetn, .pclk_en, .psel, .penable, .pready,
	.pslverr, .strap_valid, .strap_pin_nine_pull_en, .sys_rst_src, .func_oe, .strap_pin_oe,
	.boot_mode);

/* File: dv/splbs_top_tb.sv */
`timescale 1ns/1ns
`include "splbs_map.svh"
module splbs_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pclk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] sys_rst_src = 4'h0;
	logic [1:0] otp_print_sel = 2'h0;
	logic [2:0] func_out = 3'h0;
	logic [2:0] func_oe = 3'h0;
	logic [2:0] host_en = 3'h7;
	logic [2:0] host_lvl = 3'h7;
	logic [31:0] prdata, rd;
	logic [2:0] strap_pin_in, strap_pin_out, strap_pin_oe, func_in;
	logic [1:0] boot_mode;
	logic pready, pslverr, strap_pin_nine_pull_en, print_en, strap_valid, err;
	int err_count = 0;
	int checked = 0;
	// Device under test.
	splbs_top DUT (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sys_rst_src, .otp_print_sel, .strap_pin_in, .strap_pin_out,
		.strap_pin_oe, .strap_pin_nine_pull_en, .func_out, .func_oe, .func_in, .boot_mode,
		.print_en, .strap_valid);
	// Board wiring around the strap pads.
	splbs_pin_model u_pins (.pclk, .host_en, .host_lvl, .pin_out(strap_pin_out),
		.pin_oe(strap_pin_oe), .pull_en(strap_pin_nine_pull_en), .pin_in(strap_pin_in));
	// Clock at 100 MHz.
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Compare one value and count it.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One APB transfer; read data and error flag are taken at the ready edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Power up with given strap levels, then judge decode and status.
	task automatic capture(input logic [2:0] lvl, input logic [2:0] drv, input logic [1:0] sel);
		logic [2:0] s;
		logic [1:0] m;
		logic p;
		s = lvl | (~drv & 3'h4);
		m = s[2] ? 2'h0 : ((s[1] & s[0]) ? 2'h1 : 2'h2);
		p = sel == 2'h0 || (sel == 2'h1 && !s[1]) || (sel == 2'h2 && s[1]);
		@(posedge pclk);
		presetn <= 1'b0;
		host_lvl <= lvl;
		host_en <= drv;
		otp_print_sel <= sel;
		tick(2);
		presetn <= 1'b1;
		while (strap_valid !== 1'b1)
			tick(1);
		host_en <= 3'h0;
		chk("boot_mode", 32'(boot_mode), 32'(m));
		chk("print_en", 32'(print_en), 32'(p));
		apb(1'b0, `SPLBS_STRAP_STATUS_OFF, 32'h0);
		chk("strap_status", rd, 32'(s));
		apb(1'b0, `SPLBS_BOOT_STATUS_OFF, 32'h0);
		chk("boot_status", rd & 32'h1F, {27'h0, 1'b1, 1'b0, p, m});
	endtask
	// Pins return to normal use and later levels leave the capture alone.
	task automatic t_run;
		capture(3'h3, 3'h7, 2'h3);
		func_oe <= 3'h7;
		func_out <= 3'h4;
		tick(8);
		chk("pin_oe", 32'(strap_pin_oe), 32'h7);
		chk("pin_out", 32'(strap_pin_out), 32'h4);
		chk("func_in", 32'(func_in), 32'h4);
		chk("boot_mode", 32'(boot_mode), 32'h1);
		apb(1'b0, `SPLBS_STRAP_STATUS_OFF, 32'h0);
		chk("strap_status", rd, 32'h3);
		func_oe <= 3'h0;
	endtask
	// Each other reset source starts a fresh capture.
	task automatic t_recap;
		for (int j = 0; j < 4; j++) begin
			host_en <= 3'h7;
			host_lvl <= j[0] ? 3'h3 : 3'h7;
			sys_rst_src <= 4'h1 << j;
			tick(4);
			sys_rst_src <= 4'h0;
			for (int i = 0; i < 60 && boot_mode !== (j[0] ? 2'h1 : 2'h0); i++)
				tick(1);
			chk("boot_mode", 32'(boot_mode), j[0] ? 32'h1 : 32'h0);
		end
	endtask
	// Reset values, read-only and unmapped words, software print select.
	task automatic t_regs;
		apb(1'b0, `SPLBS_CTRL_OFF, 32'h0);
		chk("ctrl", rd, 32'h1);
		apb(1'b1, `SPLBS_CTRL_OFF, 32'h0);
		tick(1);
		chk("pull_en", 32'(strap_pin_nine_pull_en), 32'h0);
		apb(1'b1, `SPLBS_STRAP_STATUS_OFF, 32'h0);
		apb(1'b0, `SPLBS_STRAP_STATUS_OFF, 32'h0);
		chk("strap_status", rd, 32'h3);
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		chk("unmapped", rd, 32'h0);
		for (int q = 0; q < 4; q++) begin
			apb(1'b1, `SPLBS_PRINT_SEL_OFF, 32'(q));
			tick(2);
			chk("print_en", 32'(print_en), (q == 0 || q == 2) ? 32'h1 : 32'h0);
		end
	endtask
	// A low clock enable freezes all state, reset sources and pin samplers included.
	task automatic t_freeze;
		pclk_en <= 1'b0;
		host_lvl <= 3'h7;
		sys_rst_src <= 4'h1;
		tick(8);
		sys_rst_src <= 4'h0;
		tick(2);
		chk("frozen_func_in", 32'(func_in), 32'h3);
		pclk_en <= 1'b1;
		tick(20);
		chk("func_in", 32'(func_in), 32'h7);
		chk("boot_mode", 32'(boot_mode), 32'h1);
		apb(1'b0, `SPLBS_STRAP_STATUS_OFF, 32'h0);
		chk("strap_status", rd, 32'h3);
	endtask
	// Main sequence; the host never sets pins eight and nine both low.
	initial begin
		tick(10);
		presetn <= 1'b1;
		tick(12);
		chk("strap_valid", 32'(strap_valid), 32'h1);
		for (int s = 2; s < 8; s++)
			for (int q = 0; q < 4; q++)
				capture(3'(s), 3'h7, 2'(q));
		capture(3'h3, 3'h3, 2'h1);
		t_run();
		t_recap();
		t_regs();
		t_freeze();
		tally_and_finish();
	end
	// Cut a hang short.
	initial begin
		#400000;
		err_count++;
		tally_and_finish();
	end
endmodule
